// >>> dv/drf_link_props.sv
// Checker for the command bus between both ends.
// Assumes one mclk domain, async active-high rst.
`timescale 1ns/1ps
`include "drf_defs.svh"
module drf_link_props #(
  parameter int TREFI_CYC  = `DRF_TREFI_CYC,
  parameter int TXSDLL_CYC = `DRF_TXSDLL_CYC
) (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        cs_n,
  input wire logic        ras_n,
  input wire logic        cas_n,
  input wire logic        we_n,
  input wire logic        cke,
  input wire logic        odt,
  input wire logic [12:0] addr
);
  localparam int TXS_CYC = `DRF_TXS_CYC;
  wire nop  = cs_n | (ras_n & cas_n & we_n);
  wire refc = !cs_n & !ras_n & !cas_n & we_n & cke;
  wire sre  = !cs_n & !ras_n & !cas_n & we_n & !cke;
  wire colc = !cs_n & ras_n & !cas_n;
  int   gap_q;
  int   xs_q;
  logic ref_q;
  // Self-refresh keeps the rows alive, so the gap restarts there
  always_ff @(posedge mclk or posedge rst) begin
    if (rst)
      gap_q <= 0;
    else if (refc || !cke)
      gap_q <= 0;
    else
      gap_q <= gap_q + 1;
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst)
      xs_q <= TXSDLL_CYC;
    else if (!cke)
      xs_q <= 0;
    else if (xs_q < TXSDLL_CYC)
      xs_q <= xs_q + 1;
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst)
      ref_q <= 1'b0;
    else if (!cke)
      ref_q <= 1'b0;
    else if (refc)
      ref_q <= 1'b1;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  property p_ref_quiet; refc |=> nop[*8] ##1 nop[*2]; endproperty
  a_ref_quiet: assert property (p_ref_quiet) else $error("command inside tRFC");
  property p_ref_pre; refc |-> $past(nop) && $past(nop, 2); endproperty
  a_ref_pre: assert property (p_ref_pre) else $error("refresh too close");
  property p_ref_gap; gap_q <= 9 * TREFI_CYC; endproperty
  a_ref_gap: assert property (p_ref_gap) else $error("refresh gap too long");
  property p_sre_only; $fell(cke) |-> sre; endproperty
  a_sre_only: assert property (p_sre_only) else $error("cke fell without entry");
  property p_sre_cke; sre |=> !cke; endproperty
  a_sre_cke: assert property (p_sre_cke) else $error("cke low too short");
  property p_sre_odt; sre |-> !odt && !$past(odt); endproperty
  a_sre_odt: assert property (p_sre_odt) else $error("odt on at entry");
  property p_xs_nop; $rose(cke) |-> nop[*8] ##1 nop[*4]; endproperty
  a_xs_nop: assert property (p_xs_nop) else $error("command inside tXS");
  property p_xs_odt; cke && xs_q < TXSDLL_CYC |-> !odt; endproperty
  a_xs_odt: assert property (p_xs_odt) else $error("odt on in tXSDLL");
  property p_reentry; $fell(cke) && xs_q < TXSDLL_CYC |-> ref_q && xs_q >= TXS_CYC; endproperty
  a_reentry: assert property (p_reentry) else $error("early re-entry");
  property p_ccd; colc |=> !colc[*3]; endproperty
  a_ccd: assert property (p_ccd) else $error("column spacing short");
endmodule

// >>> dv/tb.sv
// Bench joining controller and device ends over the link.
// Assumes 100 MHz mclk; short refresh and DLL counts set here.
`timescale 1ns/1ps
module tb;
  localparam int TREFI  = 40;
  localparam int TXSDLL = 60;
  logic              mclk = 0;
  logic              rst = 1;
  logic              acc_req = 0, acc_wr = 0, acc_bl8 = 0, sr_req = 0, sr_exit = 0;
  logic [11:0]       acc_col = 12'h000, d_col;
  logic              acc_ack, sr_active, clk_stop_ok, dll_ready;
  logic signed [4:0] ref_debt;
  logic              d_stb, d_wr, d_bc4, ref_pulse, banks_idle, in_self, dll_on, dll_reset;
  logic [3:0]        ref_row;
  int                err_total = 0, check_count = 0;
  drf_link_if i_drf_link_if ();
  drf_ctrl #(.TREFI_CYC(TREFI), .TXSDLL_CYC(TXSDLL)) i_drf_ctrl (.mclk(mclk), .rst(rst),
    .link(i_drf_link_if), .acc_req(acc_req), .acc_wr(acc_wr), .acc_bl8(acc_bl8),
    .acc_col(acc_col), .acc_ack(acc_ack), .sr_req(sr_req), .sr_exit(sr_exit),
    .sr_active(sr_active), .clk_stop_ok(clk_stop_ok), .dll_ready(dll_ready),
    .ref_debt(ref_debt));
  drf_dev i_drf_dev (.mclk(mclk), .rst(rst), .link(i_drf_link_if), .acc_strobe(d_stb),
    .acc_is_wr(d_wr), .acc_bc4(d_bc4), .acc_col(d_col), .ref_pulse(ref_pulse),
    .ref_row(ref_row), .banks_idle(banks_idle), .in_self(in_self), .dll_on(dll_on),
    .dll_reset(dll_reset));
  drf_link_props #(.TREFI_CYC(TREFI), .TXSDLL_CYC(TXSDLL)) i_drf_link_props (.mclk(mclk),
    .rst(rst), .cs_n(i_drf_link_if.cs_n), .ras_n(i_drf_link_if.ras_n),
    .cas_n(i_drf_link_if.cas_n), .we_n(i_drf_link_if.we_n), .cke(i_drf_link_if.cke),
    .odt(i_drf_link_if.odt), .addr(i_drf_link_if.addr));
  always #5 mclk = ~mclk;
  task automatic chkb(input logic g, input logic e);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: flag %b not %b", $time, g, e);
    end
  endtask
  task automatic chkv(input logic [11:0] g, input logic [11:0] e);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: got %h not %h", $time, g, e);
    end
  endtask
  task automatic stop_test;
    if (err_total == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic t_access(input logic wr, input logic bl8, input logic [11:0] col);
    int n;
    @(posedge mclk);
    acc_req <= 1'b1;
    acc_wr <= wr;
    acc_bl8 <= bl8;
    acc_col <= col;
    n = 0;
    do begin tick(1); n++; end while (acc_ack !== 1'b1 && n < 400);
    chkb(acc_ack, 1'b1);
    @(posedge mclk);
    acc_req <= 1'b0;
    n = 0;
    do begin tick(1); n++; end while (d_stb !== 1'b1 && n < 6);
    chkb(d_stb, 1'b1);
    chkb(d_wr, wr);
    chkb(d_bc4, !bl8);
    chkv(d_col, col);
  endtask
  task automatic t_refresh;
    logic [3:0]        row;
    logic signed [4:0] lo;
    int                k;
    k = 0;
    lo = 5'sd0;
    repeat (600) begin
      tick(1);
      if (ref_debt < lo)
        lo = ref_debt;
      if (ref_pulse === 1'b1) begin
        if (k > 0)
          chkv({8'h00, ref_row}, {8'h00, row + 4'h1});
        row = ref_row;
        k++;
      end
    end
    chkb(k > 15, 1'b1);
    chkb(lo === -5'sd8, 1'b1);
    do tick(1); while (ref_pulse !== 1'b1);
    tick(12);
    chkb(banks_idle, 1'b1);
  endtask
  // Enter, exit, re-enter at once, then exit and wait for the DLL
  task automatic t_self;
    int n;
    for (int pass = 0; pass < 2; pass++) begin
      @(posedge mclk);
      sr_req <= 1'b1;
      n = 0;
      do begin tick(1); n++; end while (in_self !== 1'b1 && n < 800);
      chkb(in_self, 1'b1);
      chkb(sr_active, 1'b1);
      chkb(pass == 0 || n >= 12, 1'b1);
      chkb(ref_debt <= 0, 1'b1);
      n = 0;
      while (ref_pulse !== 1'b1 && n < 3) begin tick(1); n++; end
      chkb(ref_pulse, 1'b1);
      tick(3);
      chkb(dll_on, 1'b0);
      chkb(clk_stop_ok, 1'b1);
      @(posedge mclk);
      sr_req <= 1'b0;
      sr_exit <= 1'b1;
      n = 0;
      do begin tick(1); n++; end while (in_self !== 1'b0 && n < 50);
      chkb(in_self, 1'b0);
      chkb(dll_reset, 1'b1);
      chkb(sr_active, 1'b0);
      @(posedge mclk);
      sr_exit <= 1'b0;
    end
    n = 0;
    do begin tick(1); n++; end while (dll_ready !== 1'b1 && n < 200);
    chkb(n >= TXSDLL - 3 && n < TXSDLL + 10, 1'b1);
    chkb(dll_on, 1'b1);
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    t_access(1'b0, 1'b0, 12'h800);
    t_access(1'b1, 1'b1, 12'hA5C);
    t_access(1'b1, 1'b0, 12'h3FF);
    t_access(1'b0, 1'b1, 12'hFFF);
    t_refresh;
    t_self;
    stop_test;
  end
  // Whole run needs about a thousand cycles
  initial begin
    #200000;
    err_total++;
    stop_test;
  end
endmodule

// >>> logic/drf_ctrl.sv
// How it works
// - A12 low chops to four, high eight
// - A12 never used as column bit
// - Bad write strobes corrupt only that location
// - Refresh decoded from CS RAS CAS low
// - All banks precharged tRP before refresh
// - Refresh rows from internal counter only
// - Banks idle after refresh completes
// - Only NOP or deselect during tRFC
// - Average tREFI, at most eight postponed
// - At most eight pulled in count
// - Flush postponed refreshes before self-refresh
// - Self-refresh entry decoded with CKE low
// - Precharged and termination off before entry
// - Hold CKE low at least tCKE
// - DLL off in self-refresh, reset on exit
// - Ignore inputs but CKE in self-refresh
// - Internal refresh within tCKE of entry
// - Clock stop after tCKSRE, stable tCKSRX; exit goes on sr_exit without waiting tCKSRX
// - Exit waits tXS, then tXSDLL for DLL
// - CKE high through tXSDLL except re-entry
// - NOP every edge during tXS
// - Termination off throughout tXSDLL
//
// Controller end: schedules refreshes and self-refresh, issues user accesses.
// Assumes the device end on the same mclk; clock gating of the link is external.
`timescale 1ns/1ps
`include "drf_defs.svh"
module drf_ctrl #(
  parameter int TREFI_CYC  = `DRF_TREFI_CYC,
  parameter int TXSDLL_CYC = `DRF_TXSDLL_CYC
) (
  input  wire logic   mclk,
  input  wire logic   rst,
  drf_link_if.ctrl    link,
  input  wire logic   acc_req,
  input  wire logic   acc_wr,
  input  wire logic   acc_bl8,
  input  wire logic [11:0] acc_col,
  output logic        acc_ack,
  input  wire logic   sr_req,
  input  wire logic   sr_exit,
  output logic        sr_active,
  output logic        clk_stop_ok,
  output logic        dll_ready,
  output logic signed [4:0] ref_debt
);
  import drf_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_PRE, ST_RCV, ST_RFC, ST_SR, ST_XS, ST_XSDLL
  } drf_cst_t;
  localparam logic signed [4:0] DEBT_MAX = 5'(`DRF_DEBT_MAX);
  localparam logic signed [4:0] DEBT_MIN = -DEBT_MAX;

  drf_cst_t          st_q;
  logic [15:0]       cnt_q;
  logic [15:0]       refi_q;
  logic              tick;
  logic              ref_go;
  logic              sr_go;
  logic              acc_go;
  logic              xs_ref;
  logic              xs_sre;
  logic              acc_cmd;
  logic              cke_low;
  logic              reent_ok_q;
  logic              ref_in_xs_q;
  logic signed [4:0] debt_q;
  drf_cmd_t          cmd;

  assign tick = (refi_q == 16'(TREFI_CYC - 1));

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) refi_q <= 16'h0000;
    else if (tick) refi_q <= 16'h0000;
    else refi_q <= refi_q + 16'h0001;
  end

  // Debt > 0 means owed refreshes; idle time is spent paying it and pulling in.
  // At the postpone limit the refresh goes out ahead of a waiting access.
  assign ref_go = (st_q == ST_IDLE) && (debt_q > DEBT_MIN)
                  && (!acc_req || debt_q >= DEBT_MAX || (sr_req && debt_q > 5'sh00));
  assign sr_go  = (st_q == ST_IDLE) && sr_req && (debt_q <= 5'sh00);
  assign acc_go = (st_q == ST_IDLE) && acc_req && (debt_q < DEBT_MAX);
  assign xs_ref = (st_q == ST_XSDLL) && sr_req && !reent_ok_q && !ref_in_xs_q;
  assign xs_sre = (st_q == ST_XSDLL) && sr_req && reent_ok_q;

  // Ticks do not count in self-refresh: the device refreshes itself there.
  // Credit below eight pulled in is not taken; a re-entry refresh still goes out there uncounted.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) debt_q <= 5'sh00;
    else begin
      case ({tick && (st_q != ST_SR), (ref_go && !sr_go) || (xs_ref && debt_q > DEBT_MIN)})
        2'b10:   debt_q <= debt_q + 5'sh01;
        2'b01:   debt_q <= debt_q - 5'sh01;
        default: debt_q <= debt_q;
      endcase
    end
  end
  assign ref_debt = debt_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q <= ST_IDLE;
      cnt_q <= 16'h0000;
      reent_ok_q <= 1'b0;
      ref_in_xs_q <= 1'b0;
    end else begin
      cnt_q <= (cnt_q == 16'h0000) ? 16'h0000 : cnt_q - 16'h0001;
      unique case (st_q)
        ST_IDLE: begin
          if (sr_go) begin
            st_q <= ST_SR;
            cnt_q <= 16'(`DRF_TCKE_CYC + `DRF_TCKSRE_CYC);
          end else if (ref_go) begin
            st_q <= ST_RFC;
            cnt_q <= 16'(`DRF_TRFC_CYC);
          end else if (acc_go) begin
            st_q <= ST_PRE;
            cnt_q <= 16'(`DRF_TRP_CYC);
          end
        end
        // Access leaves as the count runs out; banks then get tRP to close
        ST_PRE: begin
          if (cnt_q == 16'h0000) begin
            st_q <= ST_RCV;
            cnt_q <= 16'(`DRF_TRP_CYC);
          end
        end
        ST_RCV: begin
          if (cnt_q == 16'h0000) st_q <= ST_IDLE;
        end
        ST_RFC: begin
          if (cnt_q == 16'h0000) st_q <= ref_in_xs_q ? ST_XSDLL : ST_IDLE;
        end
        ST_SR: begin
          if (cnt_q == 16'h0000 && sr_exit) begin
            st_q <= ST_XS;
            cnt_q <= 16'(`DRF_TXS_CYC);
            ref_in_xs_q <= 1'b0;
          end
        end
        ST_XS: begin
          if (cnt_q == 16'h0000) begin
            st_q <= ST_XSDLL;
            cnt_q <= 16'(TXSDLL_CYC - `DRF_TXS_CYC);
          end
        end
        // Re-entry refresh uses up the rest of the DLL wait
        ST_XSDLL: begin
          if (xs_ref) begin
            st_q <= ST_RFC;
            ref_in_xs_q <= 1'b1;
            cnt_q <= 16'(`DRF_TRFC_CYC);
          end else if (xs_sre) begin
            st_q <= ST_SR;
            cnt_q <= 16'(`DRF_TCKE_CYC + `DRF_TCKSRE_CYC);
          end else if (cnt_q == 16'h0000) begin
            st_q <= ST_IDLE;
            ref_in_xs_q <= 1'b0;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
      if (st_q == ST_RFC && ref_in_xs_q && cnt_q == 16'h0000) reent_ok_q <= 1'b1;
      if (st_q == ST_SR) reent_ok_q <= 1'b0;
    end
  end

  always_comb begin
    cmd = DRF_CMD_DES;
    if (sr_go || xs_sre) begin
      cmd = DRF_CMD_SRE;
    end else if (ref_go || xs_ref) begin
      cmd = DRF_CMD_REF;
    end else if (st_q == ST_PRE && cnt_q == 16'h0000) begin
      cmd = acc_wr ? DRF_CMD_WR : DRF_CMD_RD;
    end
  end

  assign acc_cmd = (cmd == DRF_CMD_RD) || (cmd == DRF_CMD_WR);
  // CKE stays low from entry until the exit request after the minimum stay
  assign cke_low = (cmd == DRF_CMD_SRE)
                   || (st_q == ST_SR && !(cnt_q == 16'h0000 && sr_exit));

  // Command pins are registered so the device sees clean levels each edge
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      link.cs_n <= 1'b1;
      link.ras_n <= 1'b1;
      link.cas_n <= 1'b1;
      link.we_n <= 1'b1;
      link.cke <= 1'b1;
      link.addr <= 13'h0000;
    end else begin
      link.cs_n  <= (cmd == DRF_CMD_DES);
      link.ras_n <= !(cmd == DRF_CMD_REF || cmd == DRF_CMD_SRE);
      link.cas_n <= (cmd == DRF_CMD_DES);
      link.we_n  <= !(cmd == DRF_CMD_WR);
      link.cke   <= !cke_low;
      link.addr  <= acc_cmd
                    ? {acc_bl8, 12'(acc_col)} : 13'h0000;
    end
  end

  // Termination held off; write-side termination is beyond this block
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) link.odt <= 1'b0;
    else link.odt <= 1'b0;
  end

  assign acc_ack     = acc_cmd;
  assign sr_active   = (st_q == ST_SR);
  assign clk_stop_ok = (st_q == ST_SR) && (cnt_q <= 16'(`DRF_TCKE_CYC));
  assign dll_ready   = (st_q == ST_IDLE) || (st_q == ST_PRE) || (st_q == ST_RCV);
endmodule

// >>> logic/drf_dev.sv
// Device end: decodes refresh, self-refresh and burst length commands.
// Assumes the controller obeys its own timing; inputs are same-clock logic.
`timescale 1ns/1ps
`include "drf_defs.svh"
module drf_dev (
  input  wire logic   mclk,
  input  wire logic   rst,
  drf_link_if.dev     link,
  output logic        acc_strobe,
  output logic        acc_is_wr,
  output logic        acc_bc4,
  output logic [11:0] acc_col,
  output logic        ref_pulse,
  output logic [3:0]  ref_row,
  output logic        banks_idle,
  output logic        in_self,
  output logic        dll_on,
  output logic        dll_reset
);
  import drf_pkg::*;

  drf_dev_t   st_q;
  logic [3:0] row_q;
  logic [7:0] sr_cnt_q;
  logic       cmd_ref;
  logic       cmd_sre;
  logic       cmd_rw;
  logic       sel;

  assign sel     = !link.cs_n && (st_q != DRF_DEV_SELF);
  assign cmd_ref = sel && link.cke && !link.ras_n && !link.cas_n && link.we_n;
  assign cmd_sre = sel && !link.cke && !link.ras_n && !link.cas_n && link.we_n;
  assign cmd_rw  = sel && link.ras_n && !link.cas_n;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q <= DRF_DEV_IDLE;
      sr_cnt_q <= 8'h00;
    end else begin
      unique case (st_q)
        DRF_DEV_IDLE: begin
          if (cmd_sre) begin
            st_q <= DRF_DEV_SELF;
            sr_cnt_q <= 8'h00;
          end else if (cmd_ref) st_q <= DRF_DEV_REF;
        end
        DRF_DEV_REF:  st_q <= DRF_DEV_IDLE;
        DRF_DEV_SELF: begin
          sr_cnt_q <= sr_cnt_q + 8'h01;
          if (link.cke) st_q <= DRF_DEV_XS;
        end
        DRF_DEV_XS: st_q <= cmd_sre ? DRF_DEV_SELF : DRF_DEV_IDLE;
      endcase
    end
  end

  // Refresh row comes from the internal counter; addr is never looked at
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) row_q <= 4'h0;
    else if (cmd_ref || (st_q == DRF_DEV_SELF && sr_cnt_q == 8'h00))
      row_q <= row_q + 4'h1;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ref_pulse <= 1'b0;
      ref_row <= 4'h0;
    end else begin
      ref_pulse <= cmd_ref || (st_q == DRF_DEV_SELF && sr_cnt_q == 8'h00);
      ref_row <= row_q;
    end
  end

  // A12 only picks burst length; corrupted strobes only hit that column
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      acc_strobe <= 1'b0;
      acc_is_wr <= 1'b0;
      acc_bc4 <= 1'b0;
      acc_col <= 12'h000;
    end else begin
      acc_strobe <= cmd_rw;
      acc_is_wr  <= !link.we_n;
      acc_bc4    <= !link.addr[`DRF_BC_BIT];
      acc_col    <= link.addr[11:0];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dll_on <= 1'b1;
      dll_reset <= 1'b0;
    end else begin
      dll_on <= (st_q != DRF_DEV_SELF) && !cmd_sre;
      dll_reset <= (st_q == DRF_DEV_SELF) && link.cke;
    end
  end

  assign banks_idle = (st_q != DRF_DEV_REF);
  assign in_self    = (st_q == DRF_DEV_SELF);
endmodule

// >>> pkg/drf_defs.svh
// Timing counts, field positions and size limits for the refresh link.
// Assumes a 100 MHz mclk (10 ns); all counts are in mclk cycles.
`ifndef DRF_DEFS_SVH
`define DRF_DEFS_SVH
`define DRF_CLK_NS        10
`define DRF_TRP_NS        14
`define DRF_TRFC_NS       110
`define DRF_TREFI_NS      7800
`define DRF_TCKE_NS       10
`define DRF_TCKSRE_NS     10
`define DRF_TCKSRX_NS     10
`define DRF_TXS_NS        120
`define DRF_TXSDLL_NS     5120
`define DRF_TRP_CYC       ((`DRF_TRP_NS + `DRF_CLK_NS - 1) / `DRF_CLK_NS)
`define DRF_TRFC_CYC      ((`DRF_TRFC_NS + `DRF_CLK_NS - 1) / `DRF_CLK_NS)
`define DRF_TREFI_CYC     (`DRF_TREFI_NS / `DRF_CLK_NS)
`define DRF_TCKE_CYC      ((`DRF_TCKE_NS + `DRF_CLK_NS - 1) / `DRF_CLK_NS)
`define DRF_TCKSRE_CYC    ((`DRF_TCKSRE_NS + `DRF_CLK_NS - 1) / `DRF_CLK_NS)
`define DRF_TCKSRX_CYC    ((`DRF_TCKSRX_NS + `DRF_CLK_NS - 1) / `DRF_CLK_NS)
`define DRF_TXS_CYC       ((`DRF_TXS_NS + `DRF_CLK_NS - 1) / `DRF_CLK_NS)
`define DRF_TXSDLL_CYC    ((`DRF_TXSDLL_NS + `DRF_CLK_NS - 1) / `DRF_CLK_NS)
`define DRF_BC_BIT        12
`define DRF_DLL_DIS_BIT   0
`define DRF_DEBT_MAX      8
`define DRF_ROWS          16
`define DRF_ROW_W         4
`endif

// >>> pkg/drf_link_if.sv
// Command bus between controller and memory device, one clock.
// Assumes both ends share mclk and rst.
`timescale 1ns/1ps
interface drf_link_if;
  logic        cs_n;
  logic        ras_n;
  logic        cas_n;
  logic        we_n;
  logic        cke;
  logic        odt;
  logic [12:0] addr;
  modport ctrl (output cs_n, ras_n, cas_n, we_n, cke, odt, addr);
  modport dev  (input  cs_n, ras_n, cas_n, we_n, cke, odt, addr);
endinterface

// >>> pkg/drf_pkg.sv
// Types shared by both ends of the refresh link.
// Assumes drf_defs.svh supplies the numeric constants.
package drf_pkg;
  typedef enum logic [2:0] {
    DRF_CMD_DES, DRF_CMD_NOP, DRF_CMD_REF, DRF_CMD_SRE, DRF_CMD_RD, DRF_CMD_WR, DRF_CMD_OTHER
  } drf_cmd_t;
  typedef enum logic [1:0] { DRF_DEV_IDLE, DRF_DEV_REF, DRF_DEV_SELF, DRF_DEV_XS } drf_dev_t;
endpackage
